// >>> flash_seq_regs.svh
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH
// Notes on behaviour
// - Program is setup code 40h then data, both to the target location.
// - Toggling output enable low-high-low refreshes status instead of a read-status command.
// - After the last operation write FFh to return the device to array reads.
// - Host clears status before any retry once an error flag is seen.
// - Program suspend B0h at any address; FFh reads elsewhere; D0h resumes.
// - Erase is 20h then D0h at the block address; nothing else starts it.
// - Erase suspend B0h anywhere; suspended flag valid once ready; D0h resumes.
// - Set lock bit is 60h then 01h at the block address; repeatable.
// - Clear lock bits is 60h then D0h anywhere, then FFh for array reads.

// Register offsets on the APB side
`define OFS_CTRL         12'h000
`define OFS_ADDR         12'h004
`define OFS_WDATA        12'h008
`define OFS_STATUS       12'h00C
`define OFS_RDATA        12'h010

// Control register fields
`define CTRL_OP_LSB      0
`define CTRL_GO_BIT      4
`define CTRL_PWRDN_BIT   8

// Status register fields (low byte mirrors the device status byte)
`define STAT_BUSY_BIT    8
`define STAT_SUSP_BIT    9
`define STAT_REFUSE_BIT  10
`define STAT_PWRDN_BIT   11

// Device status byte positions
`define ENGINE_READY_FLAG       7
`define SUSPENDED_FLAG          6
`define ERASE_CLEAR_ERROR_FLAG  5
`define PROGRAM_SET_ERROR_FLAG  4
`define VOLTAGE_ERROR_FLAG      3
`define PROTECT_ERROR_FLAG      1
`define ERROR_FLAG_MASK         8'h3A

// Device command codes
`define CMD_PROG_SETUP   8'h40
`define CMD_READ_ARRAY   8'hFF
`define CMD_READ_STATUS  8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_SUSPEND      8'hB0
`define CMD_CONFIRM      8'hD0
`define CMD_ERASE_SETUP  8'h20
`define CMD_LOCK_SETUP   8'h60
`define CMD_LOCK_SET     8'h01

// Pin timing, as nanoseconds and derived clock counts
`define CLK_PERIOD_NS    50
`define T_WE_LOW_NS      70
`define T_READ_ACC_NS    120
`define T_RECOVER_NS     50
`define WE_LOW_CYC       ((`T_WE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_ACC_CYC     ((`T_READ_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_CYC      ((`T_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> flash_seq_pkg.sv
package flash_seq_pkg;

  typedef enum logic [5:0]
  {
    SEQ_IDLE = 6'h01,
    SEQ_WR1  = 6'h02,
    SEQ_WR2  = 6'h04,
    SEQ_WRS  = 6'h08,
    SEQ_RDST = 6'h10,
    SEQ_RDAR = 6'h20
  } seq_state_t;

  typedef enum logic [3:0]
  {
    OP_READ_ARRAY   = 4'h0,
    OP_READ_STATUS  = 4'h1,
    OP_CLEAR_STATUS = 4'h2,
    OP_PROGRAM      = 4'h3,
    OP_ERASE        = 4'h4,
    OP_SUSPEND      = 4'h5,
    OP_RESUME       = 4'h6,
    OP_LOCK_SET     = 4'h7,
    OP_LOCK_CLEAR   = 4'h8
  } op_t;

  typedef enum logic [2:0]
  {
    CYC_IDLE    = 3'h1,
    CYC_STROBE  = 3'h2,
    CYC_RECOVER = 3'h4
  } cyc_state_t;

  typedef struct packed
  {
    cyc_state_t  st;
    logic [3:0]  cnt;
    logic        wr;
    logic [31:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        dq_oe;
  } cyc_regs_t;

  typedef struct packed
  {
    seq_state_t  st;
    op_t         op;
    logic        issued;
    logic        susp_pend;
    logic        refused;
    logic        pwrdn;
    logic [31:0] addr;
    logic [15:0] wdata;
    logic [7:0]  status;
    logic [15:0] rdata;
  } seq_regs_t;

endpackage

// >>> flash_pin_cycle.sv
`include "flash_seq_regs.svh"

// One asynchronous bus cycle on the flash pins: a write strobe or a read
module flash_pin_cycle
#(
  parameter int AW      = 24,
  parameter int WE_CYC  = `WE_LOW_CYC,
  parameter int RD_CYC  = `READ_ACC_CYC,
  parameter int REC_CYC = `RECOVER_CYC
)
(
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          clk_en,
  input  wire logic          start,
  input  wire logic          is_write,
  input  wire logic [31:0]   addr,
  input  wire logic [15:0]   wdata,
  output logic               done,
  output logic [15:0]        rdata,
  output logic               flash_ce_n,
  output logic               flash_oe_n,
  output logic               flash_we_n,
  output logic [AW-1:0]      flash_addr,
  output logic [15:0]        flash_dq_o,
  output logic               flash_dq_oe,
  input  wire logic [15:0]   flash_dq_i
);

  flash_seq_pkg::cyc_regs_t cyc_ff;
  flash_seq_pkg::cyc_regs_t nxt_cyc;

  // Done is a handshake pulse, fine as a decode
  assign done        = (cyc_ff.st == flash_seq_pkg::CYC_RECOVER) && (cyc_ff.cnt == 4'h0);
  assign rdata       = cyc_ff.rdata;
  assign flash_ce_n  = cyc_ff.ce_n;
  assign flash_oe_n  = cyc_ff.oe_n;
  assign flash_we_n  = cyc_ff.we_n;
  assign flash_addr  = cyc_ff.addr[AW-1:0];
  assign flash_dq_o  = cyc_ff.wdata;
  assign flash_dq_oe = cyc_ff.dq_oe;

  // Strobe, then a recovery gap so every read ends with output enable high
  always_comb
  begin
    nxt_cyc = cyc_ff;
    case (cyc_ff.st)
      flash_seq_pkg::CYC_IDLE:
      begin
        if (start)
        begin
          nxt_cyc.st    = flash_seq_pkg::CYC_STROBE;
          nxt_cyc.wr    = is_write;
          nxt_cyc.addr  = addr;
          nxt_cyc.wdata = wdata;
          nxt_cyc.ce_n  = 1'b0;
          nxt_cyc.we_n  = !is_write;
          nxt_cyc.oe_n  = is_write;
          nxt_cyc.dq_oe = is_write;
          nxt_cyc.cnt   = is_write ? 4'(WE_CYC - 1) : 4'(RD_CYC - 1);
        end
      end
      flash_seq_pkg::CYC_STROBE:
      begin
        if (cyc_ff.cnt == 4'h0)
        begin
          if (!cyc_ff.wr)
            nxt_cyc.rdata = flash_dq_i;
          nxt_cyc.st   = flash_seq_pkg::CYC_RECOVER;
          nxt_cyc.we_n = 1'b1;
          nxt_cyc.oe_n = 1'b1;
          nxt_cyc.ce_n = 1'b1;
          nxt_cyc.cnt  = 4'(REC_CYC - 1);
        end
        else
          nxt_cyc.cnt = cyc_ff.cnt - 4'h1;
      end
      flash_seq_pkg::CYC_RECOVER:
      begin
        // Data held one gap past the write strobe for hold time
        if (cyc_ff.cnt == 4'h0)
        begin
          nxt_cyc.st    = flash_seq_pkg::CYC_IDLE;
          nxt_cyc.dq_oe = 1'b0;
        end
        else
          nxt_cyc.cnt = cyc_ff.cnt - 4'h1;
      end
      default:
        nxt_cyc.st = flash_seq_pkg::CYC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      cyc_ff <= '{st: flash_seq_pkg::CYC_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    else if (clk_en)
      cyc_ff <= nxt_cyc;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || !clk_en);

  property p_we_drives_data;
    !flash_we_n |-> flash_dq_oe && !flash_ce_n && flash_oe_n;
  endproperty
  a_we_drives_data: assert property (p_we_drives_data) else $error("write strobe without data drive");

  property p_oe_toggles;
    (cyc_ff.st == flash_seq_pkg::CYC_STROBE) && !cyc_ff.wr && (cyc_ff.cnt == 4'h0) |=> flash_oe_n && flash_ce_n;
  endproperty
  a_oe_toggles: assert property (p_oe_toggles) else $error("output enable not raised after read");

endmodule // flash_pin_cycle

// >>> flash_command_status_sequencer.sv
// Implementation choices: the APB slave port and the placing of the registers.
`include "flash_seq_regs.svh"

// Host-side sequencer: APB registers in, flash command cycles and status polling out
module flash_command_status_sequencer
#(
  parameter int AW = 24
)
(
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          clk_en,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               flash_ce_n,
  output logic               flash_oe_n,
  output logic               flash_we_n,
  output logic [AW-1:0]      flash_addr,
  output logic [15:0]        flash_dq_o,
  output logic               flash_dq_oe,
  input  wire logic [15:0]   flash_dq_i,
  output logic               reset_powerdown_n
);

  flash_seq_pkg::seq_regs_t seq_ff;
  flash_seq_pkg::seq_regs_t nxt_seq;
  logic                     cyc_start;
  logic                     cyc_wr;
  logic [15:0]              cyc_data;
  logic                     cyc_done;
  logic [15:0]              cyc_rdata;
  logic                     apb_wr;
  logic                     go;
  flash_seq_pkg::op_t       req_op;
  logic                     err_seen;
  logic                     launch;

  // First command byte of each operation
  function automatic logic [7:0] first_code(input flash_seq_pkg::op_t op);
    case (op)
      flash_seq_pkg::OP_READ_ARRAY:   first_code = `CMD_READ_ARRAY;
      flash_seq_pkg::OP_READ_STATUS:  first_code = `CMD_READ_STATUS;
      flash_seq_pkg::OP_CLEAR_STATUS: first_code = `CMD_CLEAR_STATUS;
      flash_seq_pkg::OP_PROGRAM:      first_code = `CMD_PROG_SETUP;
      flash_seq_pkg::OP_ERASE:        first_code = `CMD_ERASE_SETUP;
      flash_seq_pkg::OP_SUSPEND:      first_code = `CMD_SUSPEND;
      flash_seq_pkg::OP_RESUME:       first_code = `CMD_CONFIRM;
      default:                        first_code = `CMD_LOCK_SETUP;
    endcase
  endfunction

  // Operations that start the embedded engine
  function automatic logic engine_op(input flash_seq_pkg::op_t op);
    engine_op = (op == flash_seq_pkg::OP_PROGRAM) || (op == flash_seq_pkg::OP_ERASE) ||
                (op == flash_seq_pkg::OP_RESUME) || (op == flash_seq_pkg::OP_LOCK_SET) ||
                (op == flash_seq_pkg::OP_LOCK_CLEAR);
  endfunction

  function automatic logic known_op(input logic [3:0] code);
    known_op = (code <= 4'h8);
  endfunction

  flash_pin_cycle #(.AW(AW)) flash_pin_cycle_inst
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .clk_en      (clk_en),
    .start       (cyc_start),
    .is_write    (cyc_wr),
    .addr        (seq_ff.addr),
    .wdata       (cyc_data),
    .done        (cyc_done),
    .rdata       (cyc_rdata),
    .flash_ce_n  (flash_ce_n),
    .flash_oe_n  (flash_oe_n),
    .flash_we_n  (flash_we_n),
    .flash_addr  (flash_addr),
    .flash_dq_o  (flash_dq_o),
    .flash_dq_oe (flash_dq_oe),
    .flash_dq_i  (flash_dq_i)
  );

  // APB slave always answers in the access cycle
  assign pready            = 1'b1;
  assign pslverr           = psel && penable && !((paddr == `OFS_CTRL) || (paddr == `OFS_ADDR) ||
                             (paddr == `OFS_WDATA) || (paddr == `OFS_STATUS) || (paddr == `OFS_RDATA));
  assign apb_wr            = psel && penable && pwrite && !pslverr;
  assign go                = apb_wr && (paddr == `OFS_CTRL) && pwdata[`CTRL_GO_BIT];
  assign req_op            = flash_seq_pkg::op_t'(pwdata[`CTRL_OP_LSB +: 4]);
  assign err_seen          = |(seq_ff.status & `ERROR_FLAG_MASK);
  assign reset_powerdown_n = !seq_ff.pwrdn;

  // Errors must be cleared before the engine is used again; no op while another runs
  assign launch = go && (seq_ff.st == flash_seq_pkg::SEQ_IDLE) && !seq_ff.pwrdn &&
                  known_op(pwdata[`CTRL_OP_LSB +: 4]) && !(engine_op(req_op) && err_seen);

  // Read mux over registered state
  always_comb
  begin
    prdata = 32'h0000_0000;
    case (paddr)
      `OFS_CTRL:   prdata = {23'h00_0000, seq_ff.pwrdn, 4'h0, seq_ff.op};
      `OFS_ADDR:   prdata = seq_ff.addr;
      `OFS_WDATA:  prdata = {16'h0000, seq_ff.wdata};
      `OFS_STATUS: prdata = {20'h0_0000, seq_ff.pwrdn, seq_ff.refused, seq_ff.susp_pend,
                             (seq_ff.st != flash_seq_pkg::SEQ_IDLE), seq_ff.status};
      `OFS_RDATA:  prdata = {16'h0000, seq_ff.rdata};
      default:     prdata = 32'h0000_0000;
    endcase
  end

  // Command sequencing and status capture
  always_comb
  begin
    nxt_seq   = seq_ff;
    cyc_start = 1'b0;
    cyc_wr    = 1'b1;
    cyc_data  = 16'h0000;
    case (seq_ff.st)
      flash_seq_pkg::SEQ_WR1:
      begin
        cyc_data  = {8'h00, first_code(seq_ff.op)};
        cyc_start = !seq_ff.issued;
      end
      flash_seq_pkg::SEQ_WR2:
      begin
        // Second write goes to the same latched address as the first
        if (seq_ff.op == flash_seq_pkg::OP_PROGRAM)
          cyc_data = seq_ff.wdata;
        else if (seq_ff.op == flash_seq_pkg::OP_LOCK_SET)
          cyc_data = {8'h00, `CMD_LOCK_SET};
        else
          cyc_data = {8'h00, `CMD_CONFIRM};
        cyc_start = !seq_ff.issued;
      end
      flash_seq_pkg::SEQ_WRS:
      begin
        cyc_data  = {8'h00, `CMD_SUSPEND};
        cyc_start = !seq_ff.issued;
      end
      flash_seq_pkg::SEQ_RDST, flash_seq_pkg::SEQ_RDAR:
      begin
        cyc_wr    = 1'b0;
        cyc_start = !seq_ff.issued;
      end
      default:
        cyc_start = 1'b0;
    endcase
    if (cyc_start)
      nxt_seq.issued = 1'b1;
    if (cyc_done)
    begin
      nxt_seq.issued = 1'b0;
      case (seq_ff.st)
        flash_seq_pkg::SEQ_WR1:
        begin
          if ((seq_ff.op == flash_seq_pkg::OP_PROGRAM) || (seq_ff.op == flash_seq_pkg::OP_ERASE) ||
              (seq_ff.op == flash_seq_pkg::OP_LOCK_SET) || (seq_ff.op == flash_seq_pkg::OP_LOCK_CLEAR))
            nxt_seq.st = flash_seq_pkg::SEQ_WR2;
          else if (seq_ff.op == flash_seq_pkg::OP_READ_ARRAY)
            nxt_seq.st = flash_seq_pkg::SEQ_RDAR;
          else if (seq_ff.op == flash_seq_pkg::OP_CLEAR_STATUS)
          begin
            nxt_seq.st     = flash_seq_pkg::SEQ_IDLE;
            nxt_seq.status = 8'h00;
          end
          else
            nxt_seq.st = flash_seq_pkg::SEQ_RDST;
        end
        flash_seq_pkg::SEQ_WR2, flash_seq_pkg::SEQ_WRS:
        begin
          nxt_seq.st        = flash_seq_pkg::SEQ_RDST;
          nxt_seq.susp_pend = 1'b0;
        end
        flash_seq_pkg::SEQ_RDST:
        begin
          // Keep refreshing status by re-strobing output enable until ready
          nxt_seq.status = cyc_rdata[7:0];
          if (cyc_rdata[`ENGINE_READY_FLAG] || (seq_ff.op == flash_seq_pkg::OP_READ_STATUS) || seq_ff.pwrdn)
          begin
            // A suspend left pending here would fire into the next, unrelated poll
            nxt_seq.st        = flash_seq_pkg::SEQ_IDLE;
            nxt_seq.susp_pend = 1'b0;
          end
          else if (seq_ff.susp_pend)
            nxt_seq.st = flash_seq_pkg::SEQ_WRS;
          else
            nxt_seq.st = flash_seq_pkg::SEQ_RDST;
        end
        default:
        begin
          nxt_seq.rdata = cyc_rdata;
          nxt_seq.st    = flash_seq_pkg::SEQ_IDLE;
        end
      endcase
    end
    // Register writes; a refused launch leaves a sticky mark until the next accepted one
    if (apb_wr && (paddr == `OFS_ADDR))
      nxt_seq.addr = pwdata;
    if (apb_wr && (paddr == `OFS_WDATA))
      nxt_seq.wdata = pwdata[15:0];
    if (apb_wr && (paddr == `OFS_CTRL))
      nxt_seq.pwrdn = pwdata[`CTRL_PWRDN_BIT];
    if (launch)
    begin
      nxt_seq.op      = req_op;
      nxt_seq.st      = flash_seq_pkg::SEQ_WR1;
      nxt_seq.refused = 1'b0;
    end
    else if (go && (req_op == flash_seq_pkg::OP_SUSPEND) && (seq_ff.st == flash_seq_pkg::SEQ_RDST) &&
             (nxt_seq.st != flash_seq_pkg::SEQ_IDLE))
      nxt_seq.susp_pend = 1'b1;
    else if (go)
      nxt_seq.refused = 1'b1;
    if (seq_ff.pwrdn)
      nxt_seq.status = 8'h00;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      seq_ff <= '{st: flash_seq_pkg::SEQ_IDLE, op: flash_seq_pkg::OP_READ_ARRAY, default: '0};
    else if (clk_en)
      seq_ff <= nxt_seq;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || !clk_en);

  property p_prog_setup;
    launch && (req_op == flash_seq_pkg::OP_PROGRAM) |=> cyc_start && (cyc_data == 16'h0040) ##1 !cyc_start;
  endproperty
  a_prog_setup: assert property (p_prog_setup) else $error("program did not open with setup code");

  property p_read_array;
    launch && (req_op == flash_seq_pkg::OP_READ_ARRAY) |=> cyc_start && (cyc_data == 16'h00FF);
  endproperty
  a_read_array: assert property (p_read_array) else $error("read array code not written");

  property p_err_refuse;
    go && err_seen && engine_op(req_op) && (seq_ff.st == flash_seq_pkg::SEQ_IDLE)
      |=> seq_ff.refused && (seq_ff.st == flash_seq_pkg::SEQ_IDLE);
  endproperty
  a_err_refuse: assert property (p_err_refuse) else $error("engine op launched over error flags");

  property p_no_queue;
    go && (req_op == flash_seq_pkg::OP_ERASE) && (seq_ff.st != flash_seq_pkg::SEQ_IDLE)
      |=> seq_ff.refused && ($stable(seq_ff.op) || $past(seq_ff.st) == flash_seq_pkg::SEQ_IDLE);
  endproperty
  a_no_queue: assert property (p_no_queue) else $error("erase queued behind a running one");

  property p_erase_confirm;
    (seq_ff.st == flash_seq_pkg::SEQ_WR2) && (seq_ff.op == flash_seq_pkg::OP_ERASE) && cyc_start
      |-> (cyc_data == 16'h00D0);
  endproperty
  a_erase_confirm: assert property (p_erase_confirm) else $error("erase not confirmed with D0");

  property p_lock_set;
    (seq_ff.st == flash_seq_pkg::SEQ_WR2) && (seq_ff.op == flash_seq_pkg::OP_LOCK_SET) && cyc_start
      |-> (cyc_data == 16'h0001) && $stable(seq_ff.addr);
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock set confirm wrong");

  property p_lock_clear;
    (seq_ff.st == flash_seq_pkg::SEQ_WR2) && (seq_ff.op == flash_seq_pkg::OP_LOCK_CLEAR) && cyc_start
      |-> (cyc_data == 16'h00D0);
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock clear confirm wrong");

  property p_ready_ends_poll;
    (seq_ff.st == flash_seq_pkg::SEQ_RDST) && cyc_done && !seq_ff.pwrdn &&
      (seq_ff.op != flash_seq_pkg::OP_READ_STATUS) && !launch
      |=> (seq_ff.st == flash_seq_pkg::SEQ_IDLE) == seq_ff.status[7];
  endproperty
  a_ready_ends_poll: assert property (p_ready_ends_poll) else $error("poll end disagrees with ready");

  property p_suspend_sent;
    go && (req_op == flash_seq_pkg::OP_SUSPEND) && (seq_ff.st == flash_seq_pkg::SEQ_RDST) && !seq_ff.pwrdn
      |-> ##[1:40] (cyc_start && (cyc_data == 16'h00B0)) || (seq_ff.st == flash_seq_pkg::SEQ_IDLE);
  endproperty
  a_suspend_sent: assert property (p_suspend_sent) else $error("suspend never written");

  property p_pwrdn_clears;
    seq_ff.pwrdn |-> !reset_powerdown_n ##1 (seq_ff.status == 8'h00);
  endproperty
  a_pwrdn_clears: assert property (p_pwrdn_clears) else $error("status kept in power-down");

endmodule // flash_command_status_sequencer

// >>> flash_dev_model.sv
module flash_dev_model
#(
  parameter int BUSY = 60
)
(
  input  wire logic        core_clk,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [23:0] addr,
  input  wire logic [15:0] dq_o,
  input  wire logic        dq_oe,
  input  wire logic        rp_n,
  input  wire logic [2:0]  knob,
  output logic      [15:0] dq_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  sr_ff = 8'h00, set_ff = 8'h00, bsy_ff = 8'h00, s;
  logic [15:0] d_ff, sh_ff = 16'h0000, last_ff = 16'h0000;
  logic [23:0] a_ff, sa_ff;
  logic        we_ff = 1'b1, oe_ff = 1'b1, st_ff = 1'b0, sus_ff = 1'b0, go;
  wire         rd_on = !(oe_n | ce_n);
  wire         rdy = bsy_ff == 8'h00 || sus_ff;
  wire  [7:0]  cmd = d_ff[7:0];
  // Released bus shows the inverse of the last value, so a stale read cannot pass
  assign dq_i = rd_on ? sh_ff : ~last_ff;
  // Commands act at the trailing edge of the write strobe
  always @(posedge core_clk)
  begin
    we_ff <= we_n | ce_n;
    oe_ff <= !rd_on;
    // Undriven data reads as garbage, so a missing drive enable spoils the command
    if (!(we_n | ce_n))
      {d_ff, a_ff} <= {dq_oe ? dq_o : ~dq_o, addr};
    if (rd_on)
      last_ff <= sh_ff;
    if (oe_ff && rd_on)
      sh_ff <= st_ff ? {8'h00, rdy, sr_ff[6:0]} : {addr[7:0], ~addr[7:0]};
    if (bsy_ff != 8'h00 && !sus_ff)
      bsy_ff <= bsy_ff - 8'h01;
    s = sr_ff;
    go = 1'b0;
    if (!we_ff && (we_n | ce_n))
    begin
      st_ff <= cmd != 8'hFF;
      set_ff <= 8'h00;
      sa_ff <= a_ff;
      if (set_ff == 8'h40)
      begin
        go = !s[3];
        s = s | {3'h0, knob[1] | (a_ff != sa_ff), knob[2], 1'b0, knob[0], 1'b0};
      end
      else if (set_ff == 8'h20)
      begin
        go = cmd == 8'hD0 && a_ff == sa_ff;
        s[5:4] = go ? {s[5] | knob[1], s[4]} : 2'b11;
      end
      else if (set_ff == 8'h60)
      begin
        go = cmd == 8'h01 || cmd == 8'hD0;
        s[3] = s[3] | knob[2];
        s[5:4] = !go ? 2'b11 : s[5:4] | (cmd[0] ? {1'b0, knob[1]} : {knob[1], 1'b0});
      end
      else if (cmd == 8'h50)
        s = s & 8'hC5;
      else if (cmd == 8'hB0 || cmd == 8'hD0)
      begin
        s[6] = cmd == 8'hB0 && bsy_ff != 8'h00;
        sus_ff <= s[6];
      end
      else if (rdy)
        set_ff <= cmd;
      if (go)
        bsy_ff <= 8'(BUSY);
    end
    sr_ff <= s;
    if (!rp_n)
      {sr_ff, st_ff, set_ff, sus_ff, bsy_ff} <= '0;
  end
endmodule // flash_dev_model

// >>> flash_command_status_sequencer_test.sv
module flash_command_status_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, en = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [2:0]  knob = 3'h0;
  logic        pready, pslverr, err, ce_n, oe_n, we_n, dq_oe, rp_n;
  logic [23:0] fa;
  logic [15:0] dq_o, dq_i;
  int          bad_count = 0, n_checks = 0, cycles = 0;
  // Fault knob {voltage, fail, locked}, operation and expected status byte
  logic [3:0]  ops [7] = '{4'h3, 4'h3, 4'h3, 4'h4, 4'h7, 4'h8, 4'h7};
  logic [2:0]  kns [7] = '{3'h4, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2, 3'h4};
  logic [7:0]  exps [7] = '{8'h88, 8'h82, 8'h90, 8'hA0, 8'h90, 8'hA0, 8'h88};

  flash_command_status_sequencer flash_command_status_sequencer_inst
  (
    .core_clk(core_clk), .rst(rst), .clk_en(en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(fa), .flash_dq_o(dq_o),
    .flash_dq_oe(dq_oe), .flash_dq_i(dq_i), .reset_powerdown_n(rp_n)
  );
  flash_dev_model flash_dev_model_inst
  (
    .core_clk(core_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fa), .dq_o(dq_o),
    .dq_oe(dq_oe), .rp_n(rp_n), .knob(knob), .dq_i(dq_i)
  );

  initial forever #25 core_clk = ~core_clk;
  // Hang guard, far above the under two thousand cycles the tests need
  always @(posedge core_clk) if (++cycles == 20000) wrap_up();

  task automatic wrap_up();
    if (cycles >= 20000)
      bad_count++;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdst(input logic [31:0] exp);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // Poll until the sequencer drops busy
  task automatic poll();
    do apb(1'b0, 12'h00C, 32'h0000_0000); while (rd[8] !== 1'b0);
  endtask

  task automatic run(input logic [3:0] op, input logic [23:0] a);
    apb(1'b1, 12'h004, {8'h00, a});
    apb(1'b1, 12'h000, {27'h0, 1'b1, op});
    poll();
  endtask

  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rdst(32'h0000_0000);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 12'h008, 32'h0000_1234);
    run(4'h3, 24'h00_0010);
    rdst(32'h0000_0080);
    run(4'h0, 24'h00_0021);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(rd, 32'h0000_21DE);
    $display("test program done");
    for (int i = 0; i < 7; i++)
    begin
      knob <= kns[i];
      run(ops[i], 24'h01_0000);
      rdst({24'h0, exps[i]});
      run(4'h1, 24'h01_0000);
      rdst({24'h0, exps[i]});
      apb(1'b1, 12'h000, {27'h0, 1'b1, ops[i]});
      rdst({20'h0, 4'h4, exps[i]});
      knob <= 3'h0;
      run(4'h2, 24'h00_0000);
      rdst(32'h0000_0000);
    end
    $display("test errors done");
    for (int i = 3; i < 5; i++)
    begin
      apb(1'b1, 12'h004, 32'h0000_0040);
      apb(1'b1, 12'h000, {27'h0, 1'b1, 4'(i)});
      do @(posedge core_clk); while (oe_n !== 1'b0);
      apb(1'b1, 12'h000, 32'h0000_0015);
      poll();
      rdst(32'h0000_00C0);
      run(4'h0, 24'h00_0033);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk(rd, 32'h0000_33CC);
      run(4'h6, 24'h00_0000);
      rdst(32'h0000_0080);
    end
    run(4'h5, 24'h00_0000);
    rdst(32'h0000_0080);
    apb(1'b1, 12'h000, 32'h0000_0014);
    apb(1'b1, 12'h000, 32'h0000_0014);
    poll();
    rdst(32'h0000_0480);
    $display("test suspend done");
    knob <= 3'h2;
    run(4'h3, 24'h00_0050);
    knob <= 3'h0;
    apb(1'b1, 12'h000, 32'h0000_0100);
    rdst(32'h0000_0800);
    chk({31'h0, rp_n}, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0000);
    run(4'h1, 24'h00_0000);
    rdst(32'h0000_0080);
    $display("test powerdown done");
    // Clock enable low: a register write must be ignored
    en <= 1'b0;
    apb(1'b1, 12'h004, 32'h0000_0077);
    en <= 1'b1;
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test freeze done");
    wrap_up();
  end
endmodule // flash_command_status_sequencer_test
